// [common/lpm_pkg.sv]
// Shared constants and types for the low-power mode controller
package lpm_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PAD_W  = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PAD_OUT = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PAD_DIR = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PULL_EN = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PULL_UP = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_PAD_IN  = 8'h18;

    // Control register fields
    localparam int CTRL_TYPE_BIT = 0;

    // Status register fields
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_MODE_MSB = 1;
    localparam int STAT_PIN_BIT  = 2;
    localparam int STAT_EN_BIT   = 3;
    localparam int STAT_PLL_BIT  = 4;
    localparam int STAT_CNT_LSB  = 8;
    localparam int STAT_CNT_MSB  = 15;
    localparam int CNT_W         = 8;

    // Reset values
    localparam logic             RST_TYPE    = 1'h0;
    localparam logic [PAD_W-1:0] RST_PAD_OUT = 8'h00;
    localparam logic [PAD_W-1:0] RST_PAD_DIR = 8'h00;
    localparam logic [PAD_W-1:0] RST_PULL_EN = 8'h00;
    localparam logic [PAD_W-1:0] RST_PULL_UP = 8'h00;
    localparam logic [CNT_W-1:0] RST_CNT     = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE     = 8'h01;

    // Freeze variants held in the control register
    localparam logic TYPE_PIN_ONLY = 1'h0;
    localparam logic TYPE_PIN_CORE = 1'h1;

    // Synchroniser input positions
    localparam int SYNC_PIN = 0;
    localparam int SYNC_EN  = 1;
    localparam int SYNC_PLL = 2;
    localparam int SYNC_PAD = 3;
    localparam int SYNC_W   = 3 + PAD_W;

    // Operating modes
    typedef enum logic [1:0] {
        LPM_ACTIVE,
        LPM_IDLE,
        LPM_FREEZE
    } lpm_mode_t;

endpackage

// [hw/lpm_sync.sv]
// Three-stage level synchroniser with agreement filter
`timescale 1ns/10ps

module lpm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] levelOut
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] agree;

    // Stage one is read only by stage two
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
        end else begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // A change counts only once stages two and three agree
    assign agree = ~(stage2_q ^ stage3_q);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            level_q <= '0;
        end else begin
            level_q <= (agree & stage3_q) | (~agree & level_q);
        end
    end

    assign levelOut = level_q;

endmodule

// [hw/lpm_ctrl.sv]
// Low-power mode controller: freeze, static idle and pad handling
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
//
// Overview of operation
// - Type 1: freeze follows the freeze request pin alone.
// - Type 2: freeze only while pin and core freeze enable both asserted.
// - Entering freeze stops every PLL clock automatically.
// - Static idle keeps memory, pad states and the configuration registers unchanged; coreIn still follows the pads.
// - Driving the PLL power-down input low turns the PLL off: static idle.
// - In freeze pads float, or hold their configured weak pull level.
// - Core logic fed from inputs sees constant high throughout freeze.

module lpm_ctrl (
    input  wire logic                        clk_sys,
    input  wire logic                        reset_n,
    // Register port
    input  wire logic [lpm_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [lpm_pkg::DATA_W-1:0]  regWdata,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic      [lpm_pkg::DATA_W-1:0]  regRdata,
    // Mode requests
    input  wire logic                        freezeRequestPin,
    input  wire logic                        coreFreezeEnable,
    input  wire logic                        pllPowerDownN,
    // PLL and core side
    output logic                             pllClkEn,
    output logic                             freezeActive,
    output logic                             staticIdle,
    output logic      [lpm_pkg::PAD_W-1:0]   coreIn,
    // Pads
    input  wire logic [lpm_pkg::PAD_W-1:0]   padIn,
    output logic      [lpm_pkg::PAD_W-1:0]   padOut,
    output logic      [lpm_pkg::PAD_W-1:0]   padOe,
    output logic      [lpm_pkg::PAD_W-1:0]   padPullEn,
    output logic      [lpm_pkg::PAD_W-1:0]   padPullUp
);
    import lpm_pkg::*;

    // Address match, shared by write and read decode
    function automatic logic hitReg(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] off);
        hitReg = (addr == off);
    endfunction

    // Software-visible state
    logic             cfgType_q;
    logic [PAD_W-1:0] padOutReg_q;
    logic [PAD_W-1:0] padDirReg_q;
    logic [PAD_W-1:0] pullEnReg_q;
    logic [PAD_W-1:0] pullUpReg_q;
    logic [CNT_W-1:0] freezeCnt_q;
    logic [CNT_W-1:0] freezeCnt_d;

    // Mode state and registered outputs
    lpm_mode_t        mode_q;
    lpm_mode_t        mode_d;
    logic             pllClkEn_q;
    logic             freezeActive_q;
    logic             staticIdle_q;
    logic [PAD_W-1:0] coreIn_q;
    logic [PAD_W-1:0] padOe_q;
    logic [PAD_W-1:0] padOut_q;
    logic [PAD_W-1:0] padPullEn_q;
    logic [PAD_W-1:0] padPullUp_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    // Synchronised levels
    logic [SYNC_W-1:0] syncIn;
    logic [SYNC_W-1:0] syncLvl;
    logic              pinLvl;
    logic              enLvl;
    logic              pllOnLvl;
    logic [PAD_W-1:0]  padLvl;

    // Decode wires
    logic wrCtrl;
    logic wrPadOut;
    logic wrPadDir;
    logic wrPullEn;
    logic wrPullUp;
    logic freezeWant;
    logic freezeEntry;
    logic [DATA_W-1:0] statusWord;

    // All pin-side levels pass one shared synchroniser
    assign syncIn = {padIn, pllPowerDownN, coreFreezeEnable, freezeRequestPin};

    lpm_sync #(
        .WIDTH    (SYNC_W)
    ) u_sync (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .asyncIn  (syncIn),
        .levelOut (syncLvl)
    );

    // Filtered levels used by the mode decision and the core inputs
    assign pinLvl   = syncLvl[SYNC_PIN];
    assign enLvl    = syncLvl[SYNC_EN];
    assign pllOnLvl = syncLvl[SYNC_PLL];
    assign padLvl   = syncLvl[SYNC_PAD +: PAD_W];

    // Freeze request: type 1 ignores the core enable entirely
    assign freezeWant = pinLvl &
                        ((cfgType_q == TYPE_PIN_ONLY) | enLvl);

    // Freeze outranks PLL power-down; both stop PLL clocks
    always_comb begin
        case (1'b1)
            freezeWant: mode_d = LPM_FREEZE;
            !pllOnLvl:  mode_d = LPM_IDLE;
            default:    mode_d = LPM_ACTIVE;
        endcase
    end

    assign freezeEntry = (mode_d == LPM_FREEZE) && (mode_q != LPM_FREEZE);

    // Register write decode
    assign wrCtrl   = regWr && hitReg(regAddr, OFF_CTRL);
    assign wrPadOut = regWr && hitReg(regAddr, OFF_PAD_OUT);
    assign wrPadDir = regWr && hitReg(regAddr, OFF_PAD_DIR);
    assign wrPullEn = regWr && hitReg(regAddr, OFF_PULL_EN);
    assign wrPullUp = regWr && hitReg(regAddr, OFF_PULL_UP);

    // Configuration changes only by explicit writes, so idle keeps it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfgType_q   <= RST_TYPE;
            padOutReg_q <= RST_PAD_OUT;
            padDirReg_q <= RST_PAD_DIR;
            pullEnReg_q <= RST_PULL_EN;
            pullUpReg_q <= RST_PULL_UP;
        end else begin
            if (wrCtrl) begin
                cfgType_q <= regWdata[CTRL_TYPE_BIT];
            end
            if (wrPadOut) begin
                padOutReg_q <= regWdata[PAD_W-1:0];
            end
            if (wrPadDir) begin
                padDirReg_q <= regWdata[PAD_W-1:0];
            end
            if (wrPullEn) begin
                pullEnReg_q <= regWdata[PAD_W-1:0];
            end
            if (wrPullUp) begin
                pullUpReg_q <= regWdata[PAD_W-1:0];
            end
        end
    end

    // Entry counter wraps; it lets software see how often freeze occurred
    assign freezeCnt_d = freezeEntry ? CNT_W'(freezeCnt_q + CNT_ONE) : freezeCnt_q;

    // Mode state and entry count
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_q      <= LPM_ACTIVE;
            freezeCnt_q <= RST_CNT;
        end else begin
            mode_q      <= mode_d;
            freezeCnt_q <= freezeCnt_d;
        end
    end

    // Outputs follow the next mode so they change with mode_q
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pllClkEn_q     <= 1'b0;
            freezeActive_q <= 1'b0;
            staticIdle_q   <= 1'b0;
        end else begin
            pllClkEn_q     <= (mode_d == LPM_ACTIVE);
            freezeActive_q <= (mode_d == LPM_FREEZE);
            staticIdle_q   <= (mode_d == LPM_IDLE);
        end
    end

    // Pad drivers released in freeze; pulls stay as configured so a
    // pulled pad settles at its weak level instead of floating
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            padOe_q     <= '0;
            padOut_q    <= RST_PAD_OUT;
            padPullEn_q <= RST_PULL_EN;
            padPullUp_q <= RST_PULL_UP;
        end else begin
            padOe_q     <= (mode_d == LPM_FREEZE) ? '0 : padDirReg_q;
            padOut_q    <= padOutReg_q;
            padPullEn_q <= pullEnReg_q;
            padPullUp_q <= pullUpReg_q;
        end
    end

    // Core inputs read high in freeze; outside clocks may still toggle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            coreIn_q <= '0;
        end else begin
            coreIn_q <= (mode_d == LPM_FREEZE) ? '1 : padLvl;
        end
    end

    // Status word assembly
    always_comb begin
        statusWord = '0;
        statusWord[STAT_MODE_MSB:STAT_MODE_LSB] = mode_q;
        statusWord[STAT_PIN_BIT] = pinLvl;
        statusWord[STAT_EN_BIT]  = enLvl;
        statusWord[STAT_PLL_BIT] = pllOnLvl;
        statusWord[STAT_CNT_MSB:STAT_CNT_LSB] = freezeCnt_q;
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = '0;
        if (regRd) begin
            if (hitReg(regAddr, OFF_CTRL)) begin
                rdata_d[CTRL_TYPE_BIT] = cfgType_q;
            end else if (hitReg(regAddr, OFF_PAD_OUT)) begin
                rdata_d[PAD_W-1:0] = padOutReg_q;
            end else if (hitReg(regAddr, OFF_PAD_DIR)) begin
                rdata_d[PAD_W-1:0] = padDirReg_q;
            end else if (hitReg(regAddr, OFF_PULL_EN)) begin
                rdata_d[PAD_W-1:0] = pullEnReg_q;
            end else if (hitReg(regAddr, OFF_PULL_UP)) begin
                rdata_d[PAD_W-1:0] = pullUpReg_q;
            end else if (hitReg(regAddr, OFF_STATUS)) begin
                rdata_d = statusWord;
            end else if (hitReg(regAddr, OFF_PAD_IN)) begin
                rdata_d[PAD_W-1:0] = coreIn_q;
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign regRdata     = rdata_q;
    assign pllClkEn     = pllClkEn_q;
    assign freezeActive = freezeActive_q;
    assign staticIdle   = staticIdle_q;
    assign coreIn       = coreIn_q;
    assign padOut       = padOut_q;
    assign padOe        = padOe_q;
    assign padPullEn    = padPullEn_q;
    assign padPullUp    = padPullUp_q;

    // Checks on the mode decision and its effects
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence pinRiseHeld;
        $rose(freezeRequestPin) ##0 freezeRequestPin [*4];
    endsequence

    sequence pinFallHeld;
        $fell(freezeRequestPin) ##0 !freezeRequestPin [*4];
    endsequence

    type1_entry_a: assert property (
        (cfgType_q == TYPE_PIN_ONLY && pinLvl) |=> freezeActive && !pllClkEn)
        else $error("type 1 pin did not freeze");

    pin_release_a: assert property (
        !pinLvl |=> !freezeActive ##0 (padOe == padDirReg_q || $past(wrPadDir)))
        else $error("freeze stayed after pin release");

    type2_gate_a: assert property (
        (cfgType_q == TYPE_PIN_CORE && pinLvl && !enLvl) |=> !freezeActive)
        else $error("type 2 froze without core enable");

    type2_entry_a: assert property (
        (cfgType_q == TYPE_PIN_CORE && pinLvl && enLvl) |=> freezeActive)
        else $error("type 2 did not freeze");

    pll_stop_a: assert property (
        $rose(freezeActive) |-> !pllClkEn ##1 (!pllClkEn || !freezeActive))
        else $error("PLL clocks ran in freeze");

    // Sampled reset leaves out the release edge, where the flops still sat in reset
    pll_down_a: assert property (
        (reset_n && !pllOnLvl && !freezeWant) |=> staticIdle && !pllClkEn)
        else $error("PLL power-down did not idle");

    pad_float_a: assert property (
        freezeActive |-> (padOe == '0) && (padPullEn == pullEnReg_q || $past(wrPullEn)))
        else $error("pad driven during freeze");

    core_high_a: assert property (
        freezeActive |-> (&coreIn))
        else $error("core input not high in freeze");

    sync_rise_a: assert property (
        pinRiseHeld |=> pinLvl)
        else $error("pin rise not seen after sync");

    sync_fall_a: assert property (
        pinFallHeld |=> !pinLvl)
        else $error("pin fall not seen after sync");

    idle_retain_a: assert property (
        (staticIdle && !regWr) |=> $stable(padOutReg_q) && $stable(padDirReg_q)
                                   && $stable(cfgType_q))
        else $error("state lost in static idle");

endmodule

// [bench/lpm_far_side.sv]
// Model of the outside system logic driving the mode pins and pad inputs
`timescale 1ns/10ps

module lpm_far_side (
    input  wire logic                      clk_sys,
    input  wire logic                      wantFreeze,
    input  wire logic                      wantEnable,
    input  wire logic                      wantPllOff,
    input  wire logic [lpm_pkg::PAD_W-1:0] padDrive,
    output logic                           freezeRequestPin,
    output logic                           coreFreezeEnable,
    output logic                           pllPowerDownN,
    output logic      [lpm_pkg::PAD_W-1:0] padIn
);
    import lpm_pkg::*;

    // Levels move just after an edge; clock keeps running in freeze.
    // Pins settle at the first edge, well inside the reset window
    always @(posedge clk_sys) begin
        freezeRequestPin <= wantFreeze;
        coreFreezeEnable <= wantEnable;
        pllPowerDownN    <= !wantPllOff;
        padIn            <= padDrive;
    end
endmodule

// [bench/testbench.sv]
// Self-checking bench for the low-power mode controller
`timescale 1ns/10ps

module testbench;
    import lpm_pkg::*;
    logic              clk_sys  = 1'b0;
    logic              clkHalt  = 1'b0;
    logic              reset_n  = 1'b0;
    logic [ADDR_W-1:0] regAddr  = 8'h00;
    logic [DATA_W-1:0] regWdata = 32'h0;
    logic              regWr    = 1'b0;
    logic              regRd    = 1'b0;
    logic              rdPend   = 1'b0;
    logic [DATA_W-1:0] regRdata;
    logic              wantFreeze = 1'b0;
    logic              wantEnable = 1'b0;
    logic              wantPllOff = 1'b0;
    logic [PAD_W-1:0]  padDrive = 8'h00;
    logic [PAD_W-1:0]  dir, pen, pup, pout;
    logic              freezeRequestPin, coreFreezeEnable, pllPowerDownN;
    logic              pllClkEn, freezeActive, staticIdle;
    logic [PAD_W-1:0]  coreIn, padIn, padOut, padOe, padPullEn, padPullUp;
    logic [DATA_W-1:0] expQ[$];
    int                failures = 0;
    int                checked  = 0;
    logic              frz;

    // Clock may be held still to model stopped incoming clocks
    always #5 if (!clkHalt) clk_sys = ~clk_sys;

    lpm_far_side lpm_far_side_i (.clk_sys(clk_sys), .wantFreeze(wantFreeze),
        .wantEnable(wantEnable), .wantPllOff(wantPllOff), .padDrive(padDrive),
        .freezeRequestPin(freezeRequestPin), .coreFreezeEnable(coreFreezeEnable),
        .pllPowerDownN(pllPowerDownN), .padIn(padIn));

    lpm_ctrl lpm_ctrl_i (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .freezeRequestPin(freezeRequestPin), .coreFreezeEnable(coreFreezeEnable),
        .pllPowerDownN(pllPowerDownN), .pllClkEn(pllClkEn), .freezeActive(freezeActive),
        .staticIdle(staticIdle), .coreIn(coreIn), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .padPullEn(padPullEn), .padPullUp(padPullUp));

    task automatic stop_test;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Strobes stay up between back-to-back requests; idle drops them
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        regRd    <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        expQ.push_back(e);
        regAddr <= a;
        regRd   <= 1'b1;
        regWr   <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic idle;
        regRd <= 1'b0;
        regWr <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rdPend) begin
            if (expQ.size() == 0)
                chk(regRdata, 32'hdeadbeef);
            else
                chk(regRdata, expQ.pop_front());
        end
        rdPend <= regRd;
    end

    // Six edges from a level change to the outputs; one spare for margin
    task automatic modeChk(input logic f, input logic i);
        repeat (7) @(posedge clk_sys);
        #1;
        chk(freezeActive, f);
        chk(staticIdle, i);
        chk(pllClkEn, !(f || i));
        chk(padOe, f ? 8'h00 : dir);
        chk({padPullEn, padPullUp}, {pen, pup});
        chk(coreIn, f ? 8'hff : padDrive);
    endtask

    initial begin
        #200000;
        failures++;
        stop_test();
    end

    initial begin
        dir = PAD_W'($urandom(74628));
        dir = PAD_W'($urandom);
        pen = PAD_W'($urandom);
        pup = PAD_W'($urandom);
        pout = PAD_W'($urandom);
        padDrive = PAD_W'($urandom);
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        // Reset values, then an unmapped place
        rd(OFF_CTRL, 32'h0);
        rd(OFF_PAD_OUT, 32'h0);
        rd(OFF_PAD_DIR, 32'h0);
        rd(OFF_PULL_EN, 32'h0);
        rd(OFF_PULL_UP, 32'h0);
        rd(8'h1c, 32'h0);
        wr(OFF_PAD_OUT, {24'h0, pout});
        wr(OFF_PAD_DIR, {24'h0, dir});
        wr(OFF_PULL_EN, {24'h0, pen});
        wr(OFF_PULL_UP, {24'h0, pup});
        wr(8'h1c, 32'hffffffff);
        rd(8'h1c, 32'h0);
        rd(OFF_PAD_OUT, {24'h0, pout});
        idle();
        chk(padOut, pout);
        modeChk(1'b0, 1'b0);
        // Every pin and enable pairing in both variants
        for (int t = 0; t < 2; t++) begin
            wr(OFF_CTRL, t);
            idle();
            for (int c = 0; c < 4; c++) begin
                wantFreeze <= c[0];
                wantEnable <= c[1];
                frz = c[0] && (t == 0 || c[1]);
                modeChk(frz, 1'b0);
            end
        end
        // Three entries counted, frozen with both inputs high
        rd(OFF_STATUS, 32'h031e);
        rd(OFF_PAD_IN, 32'h00ff);
        wantFreeze <= 1'b0;
        wantEnable <= 1'b0;
        wantPllOff <= 1'b1;
        idle();
        modeChk(1'b0, 1'b1);
        rd(OFF_STATUS, 32'h0301);
        // Freeze outranks the PLL power-down
        wantFreeze <= 1'b1;
        wantEnable <= 1'b1;
        idle();
        modeChk(1'b1, 1'b0);
        wantFreeze <= 1'b0;
        wantPllOff <= 1'b0;
        modeChk(1'b0, 1'b0);
        // Held clock: nothing may move while it stands
        #1;
        clkHalt = 1'b1;
        #200;
        clkHalt = 1'b0;
        @(posedge clk_sys);
        chk({padOut, padOe}, {pout, dir});
        rd(OFF_PAD_DIR, {24'h0, dir});
        rd(OFF_PAD_IN, {24'h0, padDrive});
        idle();
        repeat (3) @(posedge clk_sys);
        stop_test();
    end
endmodule
